//--- rtl/acrs_fifo.sv
// event record fifo with registered head
// assumes one clock; clkEn low freezes it
`timescale 1ns/1ps
`default_nettype none
module acrs_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  input  wire logic             clkEn,
  // fill side
  input  wire logic             inValid,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  inReady,
  // drain side
  output logic                  outValid,
  output logic      [WIDTH-1:0] outData,
  input  wire logic             outReady
);

  localparam int PTR_W = $clog2(DEPTH);
  localparam int CNT_W = $clog2(DEPTH + 1);
  localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);
  localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);
  localparam logic [PTR_W-1:0] PTR_ONE  = PTR_W'(1);
  localparam logic [CNT_W-1:0] CNT_ONE  = CNT_W'(1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wrPtr;
  logic [PTR_W-1:0] rdPtr;
  logic [CNT_W-1:0] count;

  wire logic headFree = !outValid || outReady;
  wire logic doPush   = inValid && inReady;
  wire logic doPop    = headFree && (count != '0);

  assign inReady = (count != CNT_FULL);

  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (clkEn && doPush) mem[wrPtr] <= inData;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end else if (clkEn) begin
      if (doPush) wrPtr <= (wrPtr == PTR_LAST) ? '0 : wrPtr + PTR_ONE;
      if (doPop) rdPtr <= (rdPtr == PTR_LAST) ? '0 : rdPtr + PTR_ONE;
      if (doPush && !doPop) count <= count + CNT_ONE;
      else if (doPop && !doPush) count <= count - CNT_ONE;
    end
  end

  // ---------------------------------------------------------------
  // head register
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      outValid <= 1'b0;
      outData  <= '0;
    end else if (clkEn) begin
      if (doPop) begin
        outValid <= 1'b1;
        outData  <= mem[rdPtr];
      end else if (outReady) begin
        outValid <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

//--- rtl/acrs_input_monitor.sv
// one clock-capable input: pin synchroniser, edge finder, lock and sync state
// assumes refPin and auxPin are asynchronous to sys_clk
`timescale 1ns/1ps
`default_nettype none
module acrs_input_monitor
  import acrs_pkg::*;
(
  // clock and reset
  input  wire logic                     sys_clk,
  input  wire logic                     rst_n,
  input  wire logic                     clkEn,
  // pins
  input  wire logic                     refPin,
  input  wire logic [1:0]               auxPin,
  // reference
  input  wire logic [acrs_pkg::HALF_W-1:0] nomHalf,
  // results
  output acrs_pkg::acrs_in_status_t     status,
  output logic                          edgeTick
);

  logic [2:0]        st1;
  logic [2:0]        st2;
  logic [2:0]        st3;
  logic [2:0]        filt;
  logic [HALF_W-1:0] halfCnt;
  logic [HALF_W-1:0] lastHalf;
  logic [2:0]        goodCnt;

  wire logic [2:0] agree = ~(st2 ^ st3);
  wire logic [2:0] next_filt = (filt & ~agree) | (st3 & agree);
  wire logic refEdge = agree[0] && (st3[0] != filt[0]);
  wire logic timedOut = (halfCnt >= LOSS_HALF);
  wire logic goodEdge = (halfCnt >= MIN_HALF) && !timedOut;
  wire logic locked = (goodCnt == LOCK_EDGES);
  wire logic [HALF_W-1:0] diff = (lastHalf > nomHalf) ? lastHalf - nomHalf
                                                        : nomHalf - lastHalf;

  // ---------------------------------------------------------------
  // three stage pin synchroniser
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      st1  <= '0;
      st2  <= '0;
      st3  <= '0;
      filt <= '0;
    end else if (clkEn) begin
      st1  <= {auxPin, refPin};
      st2  <= st1;
      st3  <= st2;
      filt <= next_filt;
    end
  end

  // ---------------------------------------------------------------
  // period measure and lock
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      halfCnt  <= '0;
      lastHalf <= '0;
      goodCnt  <= '0;
      edgeTick <= 1'b0;
    end else if (clkEn) begin
      edgeTick <= refEdge;
      if (refEdge) begin
        halfCnt  <= '0;
        lastHalf <= halfCnt;
        if (!goodEdge) goodCnt <= '0;
        else if (!locked) goodCnt <= goodCnt + 3'h1;
      end else if (timedOut) begin
        goodCnt <= '0;
      end else begin
        halfCnt <= halfCnt + HALF_ONE;
      end
    end
  end

  // ---------------------------------------------------------------
  // reported state
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      status <= '{lock: LK_NONE, rate: RATE_32K, frame96: 1'b0, ch56: 1'b0};
    end else if (clkEn) begin
      if (!locked || timedOut) status.lock <= LK_NONE;
      else if (diff <= SYNC_TOL) status.lock <= LK_SYNC;
      else status.lock <= LK_LOCK;
      status.rate    <= coarseRate(lastHalf);
      status.frame96 <= filt[1];
      status.ch56    <= filt[2];
    end
  end

endmodule
`default_nettype wire

//--- rtl/acrs_pkg.sv
// audio clock reference select: shared constants, types and decoders
// assumes a single 40 MHz system clock; all times are counted in its cycles
package acrs_pkg;

  // ---------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------
  localparam int SYS_CLK_HZ        = 40_000_000;
  localparam int SYS_CLK_PERIOD_NS = 25;
  localparam int HALF_W            = 10;
  // a reference with no edge for this long is lost
  localparam int LOSS_TIME_NS      = 20_000;
  localparam int LOSS_CYCLES       = LOSS_TIME_NS / SYS_CLK_PERIOD_NS;
  localparam logic [HALF_W-1:0] LOSS_HALF = HALF_W'(LOSS_CYCLES);
  localparam logic [HALF_W-1:0] MIN_HALF  = 10'h002;
  localparam logic [HALF_W-1:0] SYNC_TOL  = 10'h004;
  localparam logic [HALF_W-1:0] HALF_ONE  = 10'h001;
  localparam logic [2:0]        LOCK_EDGES = 3'h4;

  // ---------------------------------------------------------------
  // inputs and ports
  // ---------------------------------------------------------------
  localparam int N_IN     = 5;
  localparam int N_MADI   = 3;
  localparam int IDX_WORD = 0;
  localparam int IDX_MADI = 1;
  localparam int IDX_AES  = 4;
  localparam int FIFO_DEPTH = 4;

  localparam logic [7:0] CH_AES    = 8'h02;
  localparam logic [7:0] CH_ANALOG = 8'h04;
  localparam logic [7:0] CH_MADI   = 8'h40;
  localparam logic [7:0] CH_RED_IN = 8'h44;

  // ---------------------------------------------------------------
  // enumerations
  // ---------------------------------------------------------------
  localparam int N_RATES = 9;
  typedef enum logic [3:0] {
    RATE_32K = 4'h0, RATE_44K1 = 4'h1, RATE_48K = 4'h2,
    RATE_64K = 4'h3, RATE_88K2 = 4'h4, RATE_96K = 4'h5,
    RATE_128K = 4'h6, RATE_176K4 = 4'h7, RATE_192K = 4'h8
  } acrs_rate_t;
  localparam int RATE_HZ [N_RATES] = '{32000, 44100, 48000, 64000, 88200,
                                       96000, 128000, 176400, 192000};

  typedef enum logic [1:0] {
    SRC_INTERNAL = 2'h0, SRC_WORD = 2'h1, SRC_MADI = 2'h2, SRC_AES = 2'h3
  } acrs_src_t;

  typedef enum logic [1:0] {
    LK_NONE = 2'h0, LK_LOCK = 2'h1, LK_SYNC = 2'h2
  } acrs_lock_t;

  typedef enum logic [1:0] {
    SEL_MASTER = 2'b01, SEL_SLAVE = 2'b10
  } acrs_sel_t;

  localparam logic [1:0] MASK_SINGLE = 2'h0;
  localparam logic [1:0] MASK_DOUBLE = 2'h1;
  localparam logic [1:0] MASK_QUAD   = 2'h3;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    acrs_lock_t lock;
    acrs_rate_t rate;
    logic       frame96;
    logic       ch56;
  } acrs_in_status_t;

  typedef struct packed {
    logic frame96;
    logic ch56;
  } acrs_madi_cfg_t;

  typedef struct packed {
    logic       frame96;
    logic       ch56;
    logic [1:0] srcPort;
  } acrs_madi_out_t;

  typedef struct packed {
    acrs_src_t       src;
    logic [1:0]      madiIn;
    logic [N_IN-1:0] lockVec;
    logic [N_IN-1:0] syncVec;
  } acrs_event_t;

  // ---------------------------------------------------------------
  // decoders
  // ---------------------------------------------------------------
  function automatic logic [HALF_W-1:0] halfCount(input acrs_rate_t r);
    return HALF_W'(SYS_CLK_HZ / (2 * RATE_HZ[int'(r)]));
  endfunction

  function automatic acrs_rate_t coarseRate(input logic [HALF_W-1:0] h);
    acrs_rate_t r;
    int         mid;
    r = RATE_32K;
    for (int i = 0; i < N_RATES - 1; i++) begin
      mid = (SYS_CLK_HZ / (2 * RATE_HZ[i]) + SYS_CLK_HZ / (2 * RATE_HZ[i+1])) / 2;
      if (int'(h) <= mid) r = acrs_rate_t'(4'(i + 1));
    end
    return r;
  endfunction

  // edges per word clock toggle, minus one, in single speed
  function automatic logic [1:0] edgeMask(input acrs_rate_t r);
    if (r <= RATE_48K) return MASK_SINGLE;
    if (r <= RATE_96K) return MASK_DOUBLE;
    return MASK_QUAD;
  endfunction

endpackage

//--- rtl/acrs_top.sv
// audio clock reference select: reference choice, fallback, word clock out,
// madi output format, mirroring, input redundancy and status events
// assumes config inputs come from logic on sys_clk; reference and madi
// status pins are asynchronous and are synchronised here
`timescale 1ns/1ps
`default_nettype none
// How it works
// - word clock output follows the sample rate
// - single speed keeps word clock within 32..48 kHz
// - per port 48K or 96K frame above 48 kHz
// - mirror sends port one on ports two, three
// - redundancy: 68 inputs, standby madi ports take over
// - source internal, word, madi or aes
// - preferred valid source used, else scan in turn
// - no valid input: internal oscillator, master
// - keep checking inputs, leave internal when valid
// - lost reference reverts to internal at once
// - report source actually in use
// - per input no lock, lock or sync
// - per madi input coarse rate and frame
// - per madi input 64 or 56 channels
// - rates 32 to 192 kHz supported
// - madi output 56 or 64 channels per port
module acrs_top
  import acrs_pkg::*;
(
  // clock and reset
  input  wire logic                              sys_clk,
  input  wire logic                              rst_n,
  input  wire logic                              clkEn,
  // configuration
  input  wire acrs_pkg::acrs_src_t               prefSrc,
  input  wire logic                              forceInternal,
  input  wire acrs_pkg::acrs_rate_t              sampleRate,
  input  wire logic                              singleSpeed,
  input  wire acrs_pkg::acrs_madi_cfg_t [2:0]    madiOutCfg,
  input  wire logic                              mirrorOut,
  input  wire logic                              redundancy,
  input  wire logic                              eventClear,
  // reference and madi status pins
  input  wire logic [acrs_pkg::N_IN-1:0]         refPin,
  input  wire logic [2:0]                        madiFrame96Pin,
  input  wire logic [2:0]                        madiCh56Pin,
  // status
  output acrs_pkg::acrs_src_t                    activeSrc,
  output logic                                   masterMode,
  output logic [1:0]                             curMadiIn,
  output acrs_pkg::acrs_in_status_t [acrs_pkg::N_IN-1:0] inStatus,
  output logic [7:0]                             inChannels,
  output logic [7:0]                             outChannels,
  output logic                                   eventFlag,
  // clock and madi outputs
  output logic                                   wordClkOut,
  output acrs_pkg::acrs_madi_out_t [2:0]         madiOut,
  // event records
  output logic                                   evtValid,
  output acrs_pkg::acrs_event_t                  evtData,
  input  wire logic                              evtReady
);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // first valid of word, madi, aes starting at start, in turn
  function automatic acrs_src_t scanFrom(input acrs_src_t start, input logic [2:0] v);
    acrs_src_t s;
    int        j;
    s = SRC_INTERNAL;
    for (int k = 2; k >= 0; k--) begin
      j = (int'(start) + 2 + k) % 3;
      if (v[j]) s = acrs_src_t'(2'(j + 1));
    end
    return s;
  endfunction

  // next valid madi port after cur, in turn; cur when none
  function automatic logic [1:0] nextMadi(input logic [1:0] cur, input logic [2:0] v);
    logic [1:0] n;
    int         j;
    n = cur;
    for (int k = 2; k >= 1; k--) begin
      j = (int'(cur) + k) % 3;
      if (v[j]) n = 2'(j);
    end
    return n;
  endfunction

  function automatic logic srcValid(input acrs_src_t s, input logic [2:0] v);
    return (s == SRC_INTERNAL) ? 1'b0 : v[int'(s) - 1];
  endfunction

  // ---------------------------------------------------------------
  // input monitors
  // ---------------------------------------------------------------
  logic [N_IN-1:0]   refEdge;
  logic [N_IN-1:0]   lockVec;
  logic [N_IN-1:0]   syncVec;
  logic [1:0]        auxPins [N_IN];
  wire logic [HALF_W-1:0] nomHalf = halfCount(sampleRate);

  genvar gi;
  generate
    for (gi = 0; gi < N_IN; gi++) begin : g_mon
      if (gi >= IDX_MADI && gi < IDX_MADI + N_MADI) begin : g_madi
        assign auxPins[gi] = {madiCh56Pin[gi-IDX_MADI], madiFrame96Pin[gi-IDX_MADI]};
      end else begin : g_plain
        assign auxPins[gi] = 2'h0;
      end
      acrs_input_monitor u_mon (
        .sys_clk  (sys_clk),
        .rst_n    (rst_n),
        .clkEn    (clkEn),
        .refPin   (refPin[gi]),
        .auxPin   (auxPins[gi]),
        .nomHalf  (nomHalf),
        .status   (inStatus[gi]),
        .edgeTick (refEdge[gi])
      );
      assign lockVec[gi] = (inStatus[gi].lock != LK_NONE);
      assign syncVec[gi] = (inStatus[gi].lock == LK_SYNC);
    end
  endgenerate

  // ---------------------------------------------------------------
  // madi input redundancy
  // ---------------------------------------------------------------
  wire logic [2:0] madiLock = lockVec[IDX_MADI +: N_MADI];
  wire logic [2:0] srcLock  = {lockVec[IDX_AES], madiLock[curMadiIn], lockVec[IDX_WORD]};

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      curMadiIn <= 2'h0;
    end else if (clkEn) begin
      // fail over to a standby madi port
      if (!redundancy) curMadiIn <= 2'h0;
      else if (!madiLock[curMadiIn]) curMadiIn <= nextMadi(curMadiIn, madiLock);
    end
  end

  // ---------------------------------------------------------------
  // reference selection
  // ---------------------------------------------------------------
  acrs_sel_t state;
  acrs_sel_t next_state;
  acrs_src_t next_src;
  // pick among the four sources; forced internal
  wire logic extAllowed = !forceInternal && (prefSrc != SRC_INTERNAL);

  always_comb begin
    next_state = state;
    next_src   = activeSrc;
    unique case (state)
      SEL_MASTER: begin
        // leave the oscillator once an input is valid
        if (extAllowed && (srcLock != 3'h0)) begin
          next_state = SEL_SLAVE;
          next_src   = scanFrom(prefSrc, srcLock);
        end
      end
      SEL_SLAVE: begin
        // reference lost, back to internal at once
        if (!extAllowed || !srcValid(activeSrc, srcLock)) begin
          next_state = SEL_MASTER;
          next_src   = SRC_INTERNAL;
        // return to the preferred input when valid
        end else if (srcValid(prefSrc, srcLock)) begin
          next_src   = prefSrc;
        end
      end
      default: begin
        next_state = SEL_MASTER;
        next_src   = SRC_INTERNAL;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state      <= SEL_MASTER;
      activeSrc  <= SRC_INTERNAL;
      masterMode <= 1'b1;
    end else if (clkEn) begin
      state      <= next_state;
      // source in use, apart from prefSrc
      activeSrc  <= next_src;
      // master when running from the oscillator; others must slave
      masterMode <= (next_state == SEL_MASTER);
    end
  end

  // ---------------------------------------------------------------
  // internal oscillator and word clock output
  // ---------------------------------------------------------------
  logic [HALF_W-1:0] intCnt;
  logic              intTick;
  logic [1:0]        wcEdgeCnt;
  wire logic intWrap = (intCnt >= nomHalf - HALF_ONE);
  wire logic madiEdge = refEdge[IDX_MADI + int'(curMadiIn)];
  wire acrs_rate_t madiRate = inStatus[IDX_MADI + int'(curMadiIn)].rate;
  wire logic activeEdge = (activeSrc == SRC_WORD) ? refEdge[IDX_WORD] :
                          (activeSrc == SRC_MADI) ? madiEdge :
                          (activeSrc == SRC_AES)  ? refEdge[IDX_AES] : intTick;
  wire acrs_rate_t activeRate = (activeSrc == SRC_WORD) ? inStatus[IDX_WORD].rate :
                                (activeSrc == SRC_MADI) ? madiRate :
                                (activeSrc == SRC_AES)  ? inStatus[IDX_AES].rate :
                                sampleRate;
  // single speed divides double and quad rates down
  wire logic [1:0] wcMask = singleSpeed ? edgeMask(activeRate) : MASK_SINGLE;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      intCnt  <= '0;
      intTick <= 1'b0;
    end else if (clkEn) begin
      // half period from any supported rate
      intCnt  <= intWrap ? '0 : intCnt + HALF_ONE;
      intTick <= intWrap;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      wcEdgeCnt  <= 2'h0;
      wordClkOut <= 1'b0;
    end else if (clkEn && activeEdge) begin
      // one toggle per reference edge at full speed
      if (wcEdgeCnt >= wcMask) begin
        wcEdgeCnt  <= 2'h0;
        wordClkOut <= !wordClkOut;
      end else begin
        wcEdgeCnt  <= wcEdgeCnt + 2'h1;
      end
    end
  end

  // ---------------------------------------------------------------
  // madi outputs and channel counts
  // ---------------------------------------------------------------
  wire logic highRate = (sampleRate > RATE_48K);

  generate
    for (gi = 0; gi < N_MADI; gi++) begin : g_out
      wire acrs_madi_cfg_t cfgSel = (mirrorOut && gi > 0) ? madiOutCfg[0] : madiOutCfg[gi];
      always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
          madiOut[gi] <= '0;
        end else if (clkEn) begin
          // 96K frame only above 48 kHz
          madiOut[gi].frame96 <= cfgSel.frame96 && highRate;
          madiOut[gi].ch56    <= cfgSel.ch56;
          madiOut[gi].srcPort <= mirrorOut ? 2'h0 : 2'(gi);
        end
      end
    end
  endgenerate

  wire logic [7:0] oneMadiCh = CH_AES + CH_ANALOG + CH_MADI;
  wire logic [7:0] allMadiCh = CH_AES + CH_ANALOG + 8'(N_MADI * CH_MADI);

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      inChannels  <= allMadiCh;
      outChannels <= allMadiCh;
    end else if (clkEn) begin
      outChannels <= mirrorOut ? oneMadiCh : allMadiCh;
      inChannels  <= redundancy ? CH_RED_IN : allMadiCh;
    end
  end

  // ---------------------------------------------------------------
  // change events
  // ---------------------------------------------------------------
  acrs_event_t prevRec;
  acrs_event_t pendRec;
  logic        pending;
  logic        fifoReady;
  wire acrs_event_t curRec = '{src: activeSrc, madiIn: curMadiIn,
                               lockVec: lockVec, syncVec: syncVec};
  // any change of lock, sync or source
  wire logic changed = (curRec != prevRec);
  wire logic doPush  = pending && fifoReady;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      prevRec   <= '0;
      pendRec   <= '0;
      pending   <= 1'b0;
      eventFlag <= 1'b0;
    end else if (clkEn) begin
      prevRec <= curRec;
      // sticky flag, a new change beats the clear
      if (changed) eventFlag <= 1'b1;
      else if (eventClear) eventFlag <= 1'b0;
      if (changed) begin
        pending <= 1'b1;
        pendRec <= curRec;
      end else if (doPush) begin
        pending <= 1'b0;
      end
    end
  end

  acrs_fifo #(
    .WIDTH ($bits(acrs_event_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .clkEn    (clkEn),
    .inValid  (pending),
    .inData   (pendRec),
    .inReady  (fifoReady),
    .outValid (evtValid),
    .outData  (evtData),
    .outReady (evtReady)
  );

endmodule
`default_nettype wire

//--- tb/acrs_ref_model.sv
// far-side reference sources, 200 ns clocks
// assumes each source runs only while enabled
`timescale 1ns/1ps
`default_nettype none
module acrs_ref_model (
  // control
  input  wire logic [4:0] srcOn,
  // pins
  output logic      [4:0] refPin
);
  initial refPin = '0;
  always #100 refPin <= (refPin ^ srcOn) & srcOn;
endmodule
`default_nettype wire

//--- tb/acrs_top_monitor.sv
// checker on the reference select top level ports
// assumes clkEn held high by the bench
`timescale 1ns/1ps
`default_nettype none
module acrs_top_monitor
  import acrs_pkg::*;
(
  // clock and reset
  input wire logic                           sys_clk,
  input wire logic                           rst_n,
  // configuration
  input wire acrs_pkg::acrs_src_t            prefSrc,
  input wire logic                           forceInternal,
  input wire acrs_pkg::acrs_rate_t           sampleRate,
  input wire acrs_pkg::acrs_madi_cfg_t [2:0] madiOutCfg,
  input wire logic                           mirrorOut,
  input wire logic                           redundancy,
  input wire logic                           eventClear,
  input wire logic                           evtReady,
  // status
  input wire acrs_pkg::acrs_src_t            activeSrc,
  input wire logic                           masterMode,
  input wire logic [1:0]                     curMadiIn,
  input wire logic [7:0]                     inChannels,
  input wire logic [7:0]                     outChannels,
  input wire logic                           eventFlag,
  input wire acrs_pkg::acrs_madi_out_t [2:0] madiOut,
  input wire logic                           evtValid,
  input wire acrs_pkg::acrs_event_t          evtData
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  AST_MASTER_SRC: assert property (masterMode == (activeSrc == SRC_INTERNAL))
    else $error("master flag disagrees with source");
  AST_FORCE: assert property (forceInternal |=> masterMode)
    else $error("forced internal not master");
  AST_PREF_INT: assert property (prefSrc == SRC_INTERNAL |=> masterMode)
    else $error("internal preference not master");
  AST_FRAME: assert property ($past(rst_n) |-> madiOut[0].frame96 ==
    $past(madiOutCfg[0].frame96 && sampleRate > RATE_48K))
    else $error("output frame format wrong");
  AST_MIRROR: assert property ($past(rst_n) && $past(mirrorOut) |-> madiOut[1] == madiOut[0]
    && madiOut[2] == madiOut[0] && outChannels == 8'h46)
    else $error("mirror output wrong");
  AST_RED_CH: assert property ($past(rst_n) |->
    inChannels == ($past(redundancy) ? 8'h44 : 8'hc6))
    else $error("input channel count wrong");
  AST_RED_IN: assert property (!redundancy |=> curMadiIn == 2'h0)
    else $error("madi input moved without redundancy");
  AST_EVT_SET: assert property ($changed(activeSrc) |-> ##[1:2] eventFlag)
    else $error("source change not flagged");
  AST_EVT_CLR: assert property ($fell(eventFlag) |-> $past(eventClear))
    else $error("event flag fell unasked");
  AST_EVT_HOLD: assert property (evtValid && !evtReady |=> evtValid && $stable(evtData))
    else $error("event record dropped");
  COV_SLAVE: cover property ($fell(masterMode));
  COV_MIRROR: cover property (mirrorOut ##1 mirrorOut);
  COV_TAKE: cover property (evtValid && evtReady);
endmodule
bind acrs_top acrs_top_monitor u_acrs_top_monitor (.*);
`default_nettype wire

//--- tb/acrs_top_tb.sv
// self-checking bench for the reference select top level
// assumes the package, the source model and the checker
`timescale 1ns/1ps
`default_nettype none
module acrs_top_tb;
  import acrs_pkg::*;
  logic sys_clk = 1'b0, rst_n = 1'b0, clkEn = 1'b1;
  acrs_src_t prefSrc = SRC_WORD;
  acrs_rate_t sampleRate = RATE_96K;
  acrs_madi_cfg_t [2:0] madiOutCfg = '0;
  logic forceInternal = 1'b0, singleSpeed = 1'b0, mirrorOut = 1'b0;
  logic redundancy = 1'b0, eventClear = 1'b0, evtReady = 1'b0;
  logic [4:0] srcOn = '0;
  logic [N_IN-1:0] refPin;
  logic [2:0] madiFrame96Pin = 3'h1, madiCh56Pin = 3'h1;
  acrs_src_t activeSrc;
  logic masterMode, eventFlag, wordClkOut, evtValid;
  logic [1:0] curMadiIn;
  acrs_in_status_t [N_IN-1:0] inStatus;
  logic [7:0] inChannels, outChannels;
  acrs_madi_out_t [2:0] madiOut;
  acrs_event_t evtData;
  acrs_src_t expQ[$];
  acrs_src_t lastSrc = SRC_INTERNAL;
  int num_errors = 0, checked = 0, cyc = 0, seed = 76, n;

  always #12.5 sys_clk = ~sys_clk;
  acrs_ref_model u_acrs_ref_model (.*);
  acrs_top u_acrs_top (.*);

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run;
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // source changes taken off the queue
  always @(negedge sys_clk) if (rst_n && activeSrc !== lastSrc) begin
    lastSrc = activeSrc;
    if (expQ.size() == 0) check(16'(activeSrc), 16'hffff);
    else check(16'(activeSrc), 16'(expQ.pop_front()));
  end

  always @(posedge sys_clk) begin
    cyc++;
    {evtReady, eventClear} <= 2'($random(seed));
    if (cyc == 40000) begin
      num_errors++;
      complete_run();
    end
  end

  task automatic step(input logic [4:0] on, input acrs_src_t pref, input logic frc);
    @(posedge sys_clk);
    srcOn <= on;
    prefSrc <= pref;
    forceInternal <= frc;
    {mirrorOut, redundancy, singleSpeed} <= 3'($random(seed));
    madiOutCfg <= 6'($random(seed));
    sampleRate <= acrs_rate_t'(4'($random(seed)) % 4'h9);
    for (n = 0; n < 2000 && expQ.size() > 0; n++) @(posedge sys_clk);
    check(16'(expQ.size()), 16'h0000);
    repeat (900) @(posedge sys_clk);
  endtask

  task automatic wordTest(input logic single);
    int t;
    singleSpeed <= single;
    repeat (3) @(posedge wordClkOut);
    t = cyc;
    @(posedge wordClkOut);
    check(16'(cyc - t), 16'((single + 1) * 2 * (SYS_CLK_HZ / (2 * RATE_HZ[5]))));
  endtask

  initial begin
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    wordTest(1'b0);
    wordTest(1'b1);
    expQ.push_back(SRC_WORD);
    step(5'h01, SRC_WORD, 1'b0);
    check(16'(inStatus[IDX_WORD]), 16'({LK_LOCK, RATE_192K, 2'h0}));
    expQ.push_back(SRC_AES);
    step(5'h11, SRC_AES, 1'b0);
    expQ.push_back(SRC_INTERNAL);
    expQ.push_back(SRC_WORD);
    step(5'h01, SRC_AES, 1'b0);
    expQ.push_back(SRC_MADI);
    step(5'h03, SRC_MADI, 1'b0);
    check(16'(inStatus[IDX_MADI]), 16'({LK_LOCK, RATE_192K, 2'h3}));
    expQ.push_back(SRC_INTERNAL);
    step(5'h03, SRC_MADI, 1'b1);
    expQ.push_back(SRC_MADI);
    step(5'h03, SRC_MADI, 1'b0);
    step(5'h02, SRC_MADI, 1'b0);
    expQ.push_back(SRC_INTERNAL);
    step(5'h00, SRC_MADI, 1'b0);
    complete_run();
  end
endmodule
`default_nettype wire
